// ==== rtl/cmcs_defs.vh ====
`ifndef CMCS_DEFS_VH
`define CMCS_DEFS_VH

// ==========================================================
// Register offsets on the serial port (7-bit address)
`define CMCS_OFS_MAIN_CTRL 7'h12
`define CMCS_OFS_LOOP_TUNE 7'h14
`define CMCS_OFS_DIV_SETUP 7'h15
`define CMCS_OFS_LOCK_STAT 7'h16
`define CMCS_OFS_BAND_STAT 7'h17

// ==========================================================
// Reset values
`define CMCS_RST_MAIN_CTRL 8'h00
`define CMCS_RST_LOOP_TUNE 8'hE7
`define CMCS_RST_DIV_SETUP 8'hC9

// ==========================================================
// Field positions
`define CMCS_BIT_ENABLE 7
`define CMCS_BIT_MANUAL 6
`define CMCS_BAND_HI 5
`define CMCS_BAND_LO 0
`define CMCS_LFW_HI 7
`define CMCS_LFW_LO 5
`define CMCS_PCC_HI 4
`define CMCS_PCC_LO 0
`define CMCS_CCR_HI 7
`define CMCS_CCR_LO 6
`define CMCS_BIT_XPOINT 4
`define CMCS_OOR_HI 3
`define CMCS_OOR_LO 2
`define CMCS_FBR_HI 1
`define CMCS_FBR_LO 0
`define CMCS_BIT_LOCK 7

// ==========================================================
// Band search constants
`define CMCS_BAND_START 6'h20
`define CMCS_BAND_TOP 6'h3F
`define CMCS_BAND_BOTTOM 6'h00
`define CMCS_VOLT_MID 4'h7
`define CMCS_VOLT_WIN_HI 4'h8
`define CMCS_VOLT_WIN_LO 4'h6
`define CMCS_SETTLE_TICKS 5'h10

// ==========================================================
// Serial frame layout
`define CMCS_FRAME_BITS 5'h10
`define CMCS_ADDR_LAST 5'h07
`define CMCS_DATA_FIRST 5'h08
`define CMCS_FRAME_LAST 5'h0F

`endif

// ==== rtl/cmcs_spi_slave.v ====
`include "cmcs_defs.vh"

// ==========================================================
// Three-wire serial register port
module cmcs_spi_slave (
  input wire clk, // System clock
  input wire resetn, // Async reset, active low
  input wire sclk, // Serial clock, sampled
  input wire csn, // Chip select, active low
  input wire sdio_in, // Data pin, input side
  output reg sdio_out, // Data pin, output side
  output reg sdio_oe_n, // Data pin enable, low drives
  output reg wr_strobe, // One-cycle register write
  output reg [6:0] reg_addr, // Frame address
  output reg [7:0] wr_data, // Write data
  input wire [7:0] rd_data // Read data for reg_addr
);

  reg sclk_q;
  reg [4:0] bit_cnt;
  reg [6:0] shift;
  reg rd_frame;
  reg [7:0] tx_shift;
  wire sclk_rise;
  wire sclk_fall;

  // Edges of the sampled serial clock, only inside a frame
  assign sclk_rise = sclk & ~sclk_q & ~csn;
  assign sclk_fall = ~sclk & sclk_q & ~csn;

  // Frame engine: rise samples, fall launches read data
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      bit_cnt <= 5'h00;
      shift <= 7'h00;
      rd_frame <= 1'b0;
      tx_shift <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe_n <= 1'b1;
      wr_strobe <= 1'b0;
      reg_addr <= 7'h00;
      wr_data <= 8'h00;
    end else begin
      sclk_q <= sclk;
      wr_strobe <= 1'b0;
      if (csn) begin
        // Frame abort or end releases the pin at once
        bit_cnt <= 5'h00;
        sdio_oe_n <= 1'b1;
      end else if (sclk_rise && bit_cnt != `CMCS_FRAME_BITS) begin
        shift <= {shift[5:0], sdio_in};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == `CMCS_ADDR_LAST) begin
          rd_frame <= shift[6];
          reg_addr <= {shift[5:0], sdio_in};
        end
        if (bit_cnt == `CMCS_FRAME_LAST && !rd_frame) begin
          wr_data <= {shift[6:0], sdio_in};
          wr_strobe <= 1'b1;
        end
      end else if (sclk_fall && rd_frame && bit_cnt == `CMCS_DATA_FIRST) begin
        // Read data is captured once, so it cannot tear mid-byte
        sdio_out <= rd_data[7];
        tx_shift <= {rd_data[6:0], 1'b0};
        sdio_oe_n <= 1'b0;
      end else if (sclk_fall && rd_frame && bit_cnt > `CMCS_DATA_FIRST &&
                   bit_cnt != `CMCS_FRAME_BITS) begin
        sdio_out <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

endmodule // cmcs_spi_slave

// ==== rtl/cmcs_ref_divider.v ====
// ==========================================================
// Divides a sampled reference level by an even ratio
module cmcs_ref_divider (
  input wire clk, // System clock
  input wire resetn, // Async reset, active low
  input wire run, // Divider runs while high
  input wire ref_in, // Reference level, sampled
  input wire [4:0] ratio, // Even divide ratio, 2 to 16
  output reg div_out, // Divided level
  output reg tick // One-cycle pulse per output period
);

  reg ref_q;
  reg [3:0] edge_cnt;
  wire ref_rise;
  wire [3:0] half_last;

  assign ref_rise = ref_in & ~ref_q;
  // Half period in reference edges, minus one
  assign half_last = ratio[4:1] - 4'h1;

  // Count reference edges; toggle every half period
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_q <= 1'b0;
      edge_cnt <= 4'h0;
      div_out <= 1'b0;
      tick <= 1'b0;
    end else begin
      ref_q <= ref_in;
      tick <= 1'b0;
      if (!run) begin
        edge_cnt <= 4'h0;
        div_out <= 1'b0;
      end else if (ref_rise) begin
        if (edge_cnt >= half_last) begin
          edge_cnt <= 4'h0;
          div_out <= ~div_out;
          tick <= ~div_out;
        end else begin
          edge_cnt <= edge_cnt + 4'h1;
        end
      end
    end
  end

endmodule // cmcs_ref_divider

// ==== rtl/cmcs_top.v ====
`include "cmcs_defs.vh"

// ==========================================================
// Clock multiplier configuration and status
//
// Contract
// [RQ1] Enable bit turns multiplier on, reset off
// [RQ2] Band mode bit: 0 automatic, 1 manual
// [RQ3] Manual band code six bits, 64 bands
// [RQ4] Software keeps loop filter width at 111
// [RQ5] Software keeps pump current code at 00111
// [RQ6] Control clock is reference over 2..16
// [RQ7] Software keeps control clock below 75 MHz
// [RQ8] Software keeps crossing-point adjust off
// [RQ9] Oscillator divide 1, 2, 4, 4 by code
// [RQ10] Converter clock 2..16 times the reference
// [RQ11] Read-only lock flag, status bit 7
// [RQ12] Four-bit control voltage readback, read-only
// [RQ13] Readback mid 0111; band shifts move it
// [RQ14] Selected band readable in next status register
// [RQ15] Auto mode ignores manual band, searches itself
module cmcs_top (
  input wire clk, // System clock, 40 MHz
  input wire resetn, // Async reset, active low
  input wire spi_sclk, // Serial clock
  input wire spi_csn, // Serial chip select, active low
  input wire spi_sdio_in, // Serial data pin, input side
  output wire spi_sdio_out, // Serial data pin, output side
  output wire spi_sdio_oe_n, // Serial data pin enable, low drives
  input wire reference_clock, // Reference clock, sampled level
  input wire loop_locked, // Lock detect from the analog loop
  input wire [3:0] tuning_voltage_in, // Coarse control voltage
  output reg multiplier_enable, // Analog loop power-up
  output reg [5:0] band_code, // Oscillator band in use
  output reg [2:0] loop_filter_width, // Loop filter width code
  output reg [4:0] pump_current_code, // Charge pump current code
  output reg crosspoint_adjust_en, // Loop divider crossing adjust
  output wire converter_ready, // Lock flag as a level
  output wire control_clock, // Divided control-logic clock
  output reg [4:0] control_clock_ratio, // Reference to control ratio
  output reg [2:0] oscillator_output_ratio, // Oscillator to converter ratio
  output reg [4:0] converter_clock_ratio // Converter to reference ratio
);

  // ==========================================================
  // Decode functions

  // Power-of-two ratio 2, 4, 8, 16 from a two-bit code
  function [4:0] pow2_ratio;
    input [1:0] code;
    begin
      case (code)
        2'b00: pow2_ratio = 5'h02;
        2'b01: pow2_ratio = 5'h04;
        2'b10: pow2_ratio = 5'h08;
        default: pow2_ratio = 5'h10;
      endcase
    end
  endfunction

  // Oscillator divider: the top code repeats four
  function [2:0] osc_ratio;
    input [1:0] code;
    begin
      case (code)
        2'b00: osc_ratio = 3'h1;
        2'b01: osc_ratio = 3'h2;
        default: osc_ratio = 3'h4;
      endcase
    end
  endfunction

  // ==========================================================
  // Declarations

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SETTLE = 4'b0010;
  localparam [3:0] ST_JUDGE = 4'b0100;
  localparam [3:0] ST_HOLD = 4'b1000;

  reg [7:0] main_ctrl;
  reg [7:0] loop_tune;
  reg [7:0] div_setup;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [5:0] search_band;
  reg [5:0] next_search_band;
  reg [4:0] settle_cnt;
  reg [4:0] next_settle_cnt;
  reg lock_flag;
  reg [3:0] volt_level;
  reg [7:0] rd_data;
  wire wr_strobe;
  wire [6:0] reg_addr;
  wire [7:0] wr_data;
  wire ctl_tick;
  wire auto_mode;
  wire [5:0] band_sel;

  // ==========================================================
  // Serial port

  cmcs_spi_slave u_spi (
    .clk(clk),
    .resetn(resetn),
    .sclk(spi_sclk),
    .csn(spi_csn),
    .sdio_in(spi_sdio_in),
    .sdio_out(spi_sdio_out),
    .sdio_oe_n(spi_sdio_oe_n),
    .wr_strobe(wr_strobe),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // ==========================================================
  // Writable registers; unmapped and read-only writes are dropped

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_ctrl <= `CMCS_RST_MAIN_CTRL;
      loop_tune <= `CMCS_RST_LOOP_TUNE;
      div_setup <= `CMCS_RST_DIV_SETUP;
    end else if (wr_strobe) begin
      if (reg_addr == `CMCS_OFS_MAIN_CTRL) begin
        main_ctrl <= wr_data;
      end else if (reg_addr == `CMCS_OFS_LOOP_TUNE) begin
        loop_tune <= wr_data;
      end else if (reg_addr == `CMCS_OFS_DIV_SETUP) begin
        div_setup <= wr_data;
      end
    end
  end

  // ==========================================================
  // Read multiplexer; unmapped addresses read zero

  always @* begin
    if (reg_addr == `CMCS_OFS_MAIN_CTRL) begin
      rd_data = main_ctrl;
    end else if (reg_addr == `CMCS_OFS_LOOP_TUNE) begin
      rd_data = loop_tune;
    end else if (reg_addr == `CMCS_OFS_DIV_SETUP) begin
      rd_data = div_setup;
    end else if (reg_addr == `CMCS_OFS_LOCK_STAT) begin
      // [RQ11] [RQ12] status readback
      rd_data = {lock_flag, 3'h0, volt_level};
    end else if (reg_addr == `CMCS_OFS_BAND_STAT) begin
      // [RQ14] band readback
      rd_data = {2'h0, band_code};
    end else begin
      rd_data = 8'h00;
    end
  end

  // ==========================================================
  // Control clock divider

  // [RQ6] reference divided by 2..16
  cmcs_ref_divider u_ctl_div (
    .clk(clk),
    .resetn(resetn),
    .run(multiplier_enable),
    .ref_in(reference_clock),
    .ratio(pow2_ratio(div_setup[`CMCS_CCR_HI:`CMCS_CCR_LO])),
    .div_out(control_clock),
    .tick(ctl_tick)
  );

  // ==========================================================
  // Band search, paced by the control clock

  // [RQ15] automatic mode owns the band
  assign auto_mode = ~main_ctrl[`CMCS_BIT_MANUAL];

  // Voltage above the window means the band is too low, so step up;
  // a single step per judgement keeps the search from overshooting
  always @* begin
    next_state = state;
    next_search_band = search_band;
    next_settle_cnt = settle_cnt;
    case (state)
      ST_IDLE: begin
        next_search_band = `CMCS_BAND_START;
        next_settle_cnt = 5'h00;
        if (multiplier_enable && auto_mode) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (ctl_tick) begin
          next_settle_cnt = settle_cnt + 5'h01;
          if (settle_cnt == `CMCS_SETTLE_TICKS - 5'h01) begin
            next_state = ST_JUDGE;
          end
        end
      end
      ST_JUDGE: begin
        next_settle_cnt = 5'h00;
        // [RQ13] high voltage moves band up
        if (tuning_voltage_in > `CMCS_VOLT_WIN_HI &&
            search_band != `CMCS_BAND_TOP) begin
          next_search_band = search_band + 6'h01;
          next_state = ST_SETTLE;
        end else if (tuning_voltage_in < `CMCS_VOLT_WIN_LO &&
                     search_band != `CMCS_BAND_BOTTOM) begin
          next_search_band = search_band - 6'h01;
          next_state = ST_SETTLE;
        end else begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_settle_cnt = 5'h00;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Leaving automatic mode or disabling restarts the search
    if (!multiplier_enable || !auto_mode) begin
      next_state = ST_IDLE;
    end
  end

  // Search state registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      search_band <= `CMCS_BAND_START;
      settle_cnt <= 5'h00;
    end else begin
      state <= next_state;
      search_band <= next_search_band;
      settle_cnt <= next_settle_cnt;
    end
  end

  // [RQ2] [RQ3] band source by mode
  assign band_sel = auto_mode ? search_band : main_ctrl[`CMCS_BAND_HI:`CMCS_BAND_LO];

  // ==========================================================
  // Registered controls toward the analog loop

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      multiplier_enable <= 1'b0;
      band_code <= 6'h00;
      loop_filter_width <= 3'h0;
      pump_current_code <= 5'h00;
      crosspoint_adjust_en <= 1'b0;
      control_clock_ratio <= 5'h02;
      oscillator_output_ratio <= 3'h1;
      converter_clock_ratio <= 5'h02;
    end else begin
      // [RQ1] enable follows bit 7
      multiplier_enable <= main_ctrl[`CMCS_BIT_ENABLE];
      band_code <= band_sel;
      // [RQ4] filter width code passed through
      loop_filter_width <= loop_tune[`CMCS_LFW_HI:`CMCS_LFW_LO];
      // [RQ5] pump current code passed through
      pump_current_code <= loop_tune[`CMCS_PCC_HI:`CMCS_PCC_LO];
      // [RQ8] crossing adjust enable
      crosspoint_adjust_en <= div_setup[`CMCS_BIT_XPOINT];
      // [RQ7] ratio shown for software's check
      control_clock_ratio <= pow2_ratio(div_setup[`CMCS_CCR_HI:`CMCS_CCR_LO]);
      // [RQ9] oscillator divider decode
      oscillator_output_ratio <= osc_ratio(div_setup[`CMCS_OOR_HI:`CMCS_OOR_LO]);
      // [RQ10] feedback divider decode
      converter_clock_ratio <= pow2_ratio(div_setup[`CMCS_FBR_HI:`CMCS_FBR_LO]);
    end
  end

  // ==========================================================
  // Status capture

  // In automatic mode lock is only claimed once the search reaches ST_HOLD, so a mid-search
  // lock pulse from the analog loop is not reported; in manual mode the flag follows loop_locked
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_flag <= 1'b0;
      volt_level <= 4'h0;
    end else begin
      // [RQ11] lock flag qualified
      lock_flag <= multiplier_enable & loop_locked & (~auto_mode | (state == ST_HOLD));
      // [RQ12] voltage readback, zero when off
      volt_level <= multiplier_enable ? tuning_voltage_in : 4'h0;
    end
  end

  // Lock flag as a pin for the converter clock gating
  assign converter_ready = lock_flag;

endmodule // cmcs_top

// ==== test/cmcs_top_monitor.sv ====
// ==========================================================
// Port-level checks on the multiplier control block
module cmcs_top_monitor (
  input logic clk, // System clock
  input logic resetn, // Async reset, active low
  input logic spi_csn, // Chip select
  input logic spi_sdio_oe_n, // Pin enable, low drives
  input logic loop_locked, // Analog lock detect
  input logic multiplier_enable, // Loop power-up
  input logic [5:0] band_code, // Band in use
  input logic converter_ready, // Lock flag
  input logic control_clock, // Divided clock
  input logic [4:0] control_clock_ratio, // Control ratio
  input logic [2:0] oscillator_output_ratio, // Oscillator ratio
  input logic [4:0] converter_clock_ratio // Converter ratio
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Lock flag is registered from the analog detect
  lock_needs_input_a: assert property (!loop_locked |=> !converter_ready)
    else $error("lock flag high without loop lock");
  // Two cycles of slack cover either enable path into the flag
  lock_needs_enable_a: assert property (!multiplier_enable [*2] |-> !converter_ready)
    else $error("lock flag high while disabled");
  ctl_ratio_legal_a: assert property (control_clock_ratio inside {5'h02, 5'h04, 5'h08, 5'h10})
    else $error("control ratio outside 2 4 8 16");
  osc_ratio_legal_a: assert property (oscillator_output_ratio inside {3'h1, 3'h2, 3'h4})
    else $error("oscillator ratio outside 1 2 4");
  conv_ratio_legal_a: assert property (converter_clock_ratio inside {5'h02, 5'h04, 5'h08, 5'h10})
    else $error("converter ratio outside 2 4 8 16");
  clock_idle_a: assert property (!multiplier_enable [*3] |-> !control_clock)
    else $error("control clock runs while disabled");
  pin_release_a: assert property (spi_csn [*4] |-> spi_sdio_oe_n)
    else $error("data pin driven while deselected");
  pin_drive_a: assert property ($fell(spi_sdio_oe_n) |-> !spi_csn)
    else $error("data pin driven outside a frame");

  cover property ($rose(converter_ready));
  cover property (multiplier_enable && $changed(band_code));
  cover property ($fell(spi_sdio_oe_n));
endmodule // cmcs_top_monitor

bind cmcs_top cmcs_top_monitor mon (.clk(clk), .resetn(resetn), .spi_csn(spi_csn),
  .spi_sdio_oe_n(spi_sdio_oe_n), .loop_locked(loop_locked),
  .multiplier_enable(multiplier_enable), .band_code(band_code),
  .converter_ready(converter_ready), .control_clock(control_clock),
  .control_clock_ratio(control_clock_ratio), .oscillator_output_ratio(oscillator_output_ratio),
  .converter_clock_ratio(converter_clock_ratio));

// ==== test/cmcs_top_bench.sv ====
// ==========================================================
// Self-checking bench for the multiplier control block
module cmcs_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, spi_sclk, spi_csn, bench_bit, reference_clock, loop_locked;
  logic [3:0] tuning_voltage_in;
  wire spi_sdio_in, spi_sdio_out, spi_sdio_oe_n, multiplier_enable, crosspoint_adjust_en;
  wire converter_ready, control_clock;
  wire [5:0] band_code;
  wire [2:0] loop_filter_width, oscillator_output_ratio;
  wire [4:0] pump_current_code, control_clock_ratio, converter_clock_ratio;
  int n_mismatch, comparisons, k, n;
  logic [7:0] d;
  logic [5:0] b;

  // Shared data wire: the device wins while its enable is low
  assign spi_sdio_in = spi_sdio_oe_n ? bench_bit : spi_sdio_out;

  cmcs_top uut (.clk(clk), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_n(spi_sdio_oe_n),
    .reference_clock(reference_clock), .loop_locked(loop_locked),
    .tuning_voltage_in(tuning_voltage_in), .multiplier_enable(multiplier_enable),
    .band_code(band_code), .loop_filter_width(loop_filter_width),
    .pump_current_code(pump_current_code), .crosspoint_adjust_en(crosspoint_adjust_en),
    .converter_ready(converter_ready), .control_clock(control_clock),
    .control_clock_ratio(control_clock_ratio),
    .oscillator_output_ratio(oscillator_output_ratio),
    .converter_clock_ratio(converter_clock_ratio));

  // ==========================================================
  // Clocks and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Reference at a quarter of clk, well inside the sampling limit
  // a 10 MHz reference keeps every control clock ratio under the limit
  initial begin
    reference_clock = 1'b0;
    forever begin
      repeat (2) @(negedge clk);
      reference_clock = ~reference_clock;
    end
  end
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] pow_exp(input logic [1:0] c);
    return 8'h02 << c;
  endfunction
  function automatic logic [7:0] osc_exp(input logic [1:0] c);
    return (c == 2'h0) ? 8'h01 : (c == 2'h1) ? 8'h02 : 8'h04;
  endfunction
  task automatic wait_clk(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Cycles from one rising control clock edge to the next
  task automatic ctl_period(output int p);
    p = 0;
    while (control_clock !== 1'b0) begin
      wait_clk(1);
    end
    while (control_clock !== 1'b1) begin
      wait_clk(1);
    end
    while (control_clock !== 1'b0) begin
      wait_clk(1);
      p++;
    end
    while (control_clock !== 1'b1) begin
      wait_clk(1);
      p++;
    end
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One whole frame; sclk levels last 4 clk so the sampler sees each one
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] q);
    logic [15:0] bits;
    int i;
    bits = {rw, a, wd};
    q = 8'h00;
    spi_csn = 1'b0;
    for (i = 15; i >= 0; i--) begin
      bench_bit = bits[i];
      wait_clk(4);
      if (i < 8) q[i] = spi_sdio_out;
      spi_sclk = 1'b1;
      wait_clk(4);
      spi_sclk = 1'b0;
    end
    wait_clk(4);
    spi_csn = 1'b1;
    wait_clk(4);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] wd);
    logic [7:0] q;
    frame(1'b0, a, wd, q);
  endtask
  task automatic rd_chk(input string name, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    frame(1'b1, a, 8'($urandom), q);
    check(name, exp, q);
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    bench_bit = 1'b0;
    loop_locked = 1'b0;
    tuning_voltage_in = 4'h7;
    n_mismatch = 0;
    comparisons = 0;
    k = $urandom(32'h46F5728D);
    wait_clk(5);
    resetn = 1'b1;
    wait_clk(2);
    check("enable", 8'h00, multiplier_enable);
    check("width", 8'h07, loop_filter_width);
    check("current", 8'h07, pump_current_code);
    check("ctl ratio", 8'h10, control_clock_ratio);
    check("osc ratio", 8'h04, oscillator_output_ratio);
    check("conv ratio", 8'h04, converter_clock_ratio);
    rd_chk("main reg", 7'h12, 8'h00);
    rd_chk("tune reg", 7'h14, 8'hE7);
    rd_chk("div reg", 7'h15, 8'hC9);
    rd_chk("lock reg", 7'h16, 8'h00);
    rd_chk("unmapped", 7'h13, 8'h00);
    // Every divider code, other fields random
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      d[7:6] = k[1:0];
      d[5] = 1'b0;
      d[3:2] = k[1:0];
      d[1:0] = k[1:0];
      wr(7'h15, d);
      check("ctl ratio", pow_exp(d[7:6]), control_clock_ratio);
      check("osc ratio", osc_exp(d[3:2]), oscillator_output_ratio);
      check("conv ratio", pow_exp(d[1:0]), converter_clock_ratio);
      check("xpoint", {7'h00, d[4]}, crosspoint_adjust_en);
      rd_chk("div reg", 7'h15, d);
      d = $urandom;
      wr(7'h14, d);
      check("width", {5'h00, d[7:5]}, loop_filter_width);
      check("current", {3'h0, d[4:0]}, pump_current_code);
    end
    // Manual bands: both ends and one random
    loop_locked = 1'b1;
    tuning_voltage_in = 4'hB;
    for (k = 0; k < 3; k++) begin
      b = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($urandom);
      wr(7'h12, {2'b11, b});
      check("enable", 8'h01, multiplier_enable);
      check("band", {2'b00, b}, band_code);
      check("ready", 8'h01, converter_ready);
      rd_chk("lock reg", 7'h16, 8'h8B);
      rd_chk("band reg", 7'h17, {2'b00, b});
    end
    // Last divider write left code 11; reference period is 4 clk
    ctl_period(n);
    check("ctl period", pow_exp(2'h3) << 2, 8'(n));
    wr(7'h16, 8'h00);
    rd_chk("lock reg", 7'h16, 8'h8B);
    loop_locked = 1'b0;
    wait_clk(3);
    check("ready", 8'h00, converter_ready);
    loop_locked = 1'b1;
    // Automatic search, fastest control clock, climbing then falling
    wr(7'h15, 8'h09);
    for (k = 0; k < 2; k++) begin
      wr(7'h12, 8'h00);
      tuning_voltage_in = (k == 0) ? 4'hC : 4'h3;
      b = (k == 0) ? 6'h3F : 6'h00;
      wr(7'h12, 8'h95);
      check("start band", 8'h20, band_code);
      n = 0;
      while (band_code !== b && n < 6000) begin
        wait_clk(1);
        n++;
      end
      check("end band", {2'b00, b}, band_code);
      check("ready", 8'h00, converter_ready);
      tuning_voltage_in = 4'h7;
      n = 0;
      while (converter_ready !== 1'b1 && n < 1000) begin
        wait_clk(1);
        n++;
      end
      check("ready", 8'h01, converter_ready);
      rd_chk("lock reg", 7'h16, 8'h87);
      rd_chk("band reg", 7'h17, {2'b00, b});
      ctl_period(n);
      check("ctl period", pow_exp(2'h0) << 2, 8'(n));
    end
    // Reset in mid-run: registers and status fall back to reset state
    resetn = 1'b0;
    wait_clk(5);
    resetn = 1'b1;
    wait_clk(2);
    check("enable", 8'h00, multiplier_enable);
    check("ready", 8'h00, converter_ready);
    check("band", 8'h20, band_code);
    check("ctl ratio", 8'h10, control_clock_ratio);
    rd_chk("main reg", 7'h12, 8'h00);
    rd_chk("lock reg", 7'h16, 8'h00);
    finish_test();
  end
endmodule // cmcs_top_bench
